// ==== link_pkg.sv ====
// Purpose: Shared constants and types for the four-port serial byte link
// Assumes: One 25 MHz clock, synchronous active-high reset
// Notes: Bit timing is kept in nanoseconds by a fractional accumulator
package link_pkg;

  // ----------------------------------------------------------------
  // Clock and line timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
  localparam int BIT_NS_STD = 100;
  localparam int BIT_NS_SLOW = 200;
  localparam int BIT_NS_FAST = 50;
  localparam int ACC_W = 9;
  localparam logic [ACC_W-1:0] CLK_STEP = ACC_W'(CLK_NS);

  // ----------------------------------------------------------------
  // Packet shape and sizes
  // ----------------------------------------------------------------
  localparam int NPORTS = 4;
  localparam int DATA_BITS = 8;
  localparam int PKT_W = 11;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] DATA_PKT_BITS = 4'hB;
  localparam logic [CNT_W-1:0] ACK_PKT_BITS = 4'h2;
  localparam logic [CNT_W-1:0] LAST_DATA_IDX = 4'h7;
  localparam logic [PKT_W-1:0] ACK_PKT = 11'h001;
  localparam int FIFO_DEPTH = 32;

  typedef logic [DATA_BITS-1:0] byte_t;

  typedef struct packed {
    byte_t data;
    logic last;
  } tx_req_t;

  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_TYPE, RX_DATA, RX_STOP} rx_state_t;
  typedef enum logic [0:0] {TX_IDLE, TX_SEND} tx_state_t;

  typedef struct packed {
    logic [1:0] spd_meta;
    logic [1:0] spd_sync;
    logic rx_meta;
    logic rx_sync;
    logic rx_prev;
    rx_state_t rx_state;
    logic [ACC_W-1:0] rx_acc;
    logic [CNT_W-1:0] rx_cnt;
    byte_t rx_shift;
    logic hold_valid;
    byte_t hold_data;
    logic ack_pending;
    logic ack_seen;
    tx_state_t tx_state;
    logic [ACC_W-1:0] tx_acc;
    logic [CNT_W-1:0] tx_cnt;
    logic [PKT_W-1:0] tx_shift;
    logic tx_held;
    tx_req_t tx_buf;
    logic await_ack;
    logic await_last;
    logic done;
    logic line;
  } port_state_t;

  // Bit period from {global, per-port} select
  function automatic logic [ACC_W-1:0] bit_period(input logic [1:0] sel);
    logic [ACC_W-1:0] p;
    p = ACC_W'(BIT_NS_STD);
    case (sel)
      2'h1: p = ACC_W'(BIT_NS_SLOW);
      2'h3: p = ACC_W'(BIT_NS_FAST);
      default: p = ACC_W'(BIT_NS_STD);
    endcase
    return p;
  endfunction

endpackage

// ==== byte_fifo.sv ====
// Purpose: Synchronous FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes: Full and empty come from pointers with one extra wrap bit
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } fifo_state_t;

  fifo_state_t st_q, st_d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic full, empty, push, pop;

  assign empty = (st_q.wr == st_q.rd);
  assign full = (st_q.wr[AW] != st_q.rd[AW]) && (st_q.wr[AW-1:0] == st_q.rd[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[st_q.rd[AW-1:0]];
  assign push = in_valid && !full;
  assign pop = out_ready && !empty;

  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.wr = st_q.wr + 1'b1;
    end
    if (pop) begin
      st_d.rd = st_q.rd + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem[st_q.wr[AW-1:0]] <= in_data;
    end
  end

endmodule

// ==== serial_link_ports.sv ====
// Purpose: Four-port serial byte link engine with per-byte acknowledge
// Assumes: Line inputs and speed selects are asynchronous pins
// Notes: At 20 Mbit/s the line is sampled barely above once per bit
//
// Notes on behaviour
// R1 - Four identical ports, each with independent receive and transmit channels.
// R2 - Every received data byte is answered by an acknowledge on our output.
// R3 - Output line stays low whenever no packet is being sent.
// R4 - Data packet: high start, one, eight data bits, low stop.
// R5 - Payload bits go least significant first.
// R6 - Acknowledge packet: high start then zero, then line low.
// R7 - No new data packet until the previous one is acknowledged.
// R8 - Acknowledge only once the byte is taken and another fits.
// R9 - Message completion reported only after last byte is acknowledged.
// R10 - Line rates of 10, 5 and 20 Mbit/s; both ends match.
// R11 - Rate from global and per-port select: 00=10, 01=5, 10=10, 11=20.
// R12 - Port 0 has its own select; ports 1 to 3 share one.
// R13 - No phase relation to our clock assumed; line is resynchronised.
// R14 - Oversample, find rising start, second bit one means data, zero ack.
// R15 - Acknowledges may be sent between our own data packets.
module serial_link_ports
  import link_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic global_speed_select,
  input wire logic port0_speed_select,
  input wire logic ports123_speed_select,
  input wire logic [link_pkg::NPORTS-1:0] serial_rx_line,
  output logic [link_pkg::NPORTS-1:0] serial_tx_line,
  input wire logic [link_pkg::NPORTS-1:0] tx_valid,
  input wire link_pkg::tx_req_t [link_pkg::NPORTS-1:0] tx_req,
  output logic [link_pkg::NPORTS-1:0] tx_ready,
  output logic [link_pkg::NPORTS-1:0] tx_done,
  output logic [link_pkg::NPORTS-1:0] rx_valid,
  output link_pkg::byte_t [link_pkg::NPORTS-1:0] rx_data,
  input wire logic [link_pkg::NPORTS-1:0] rx_ready
);
  import link_pkg::*;

  // ----------------------------------------------------------------
  // One identical engine per port
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NPORTS; i++) begin : g_port // [R1]
    port_state_t q, s;
    logic fifo_in_ready;
    logic local_sel;
    logic [ACC_W-1:0] period;
    logic [ACC_W-1:0] rx_sum;
    logic [ACC_W-1:0] tx_sum;
    logic [ACC_W-1:0] half_sum;
    logic rx_tick, tx_tick, push, accept;

    if (i == 0) begin : g_sel0
      assign local_sel = port0_speed_select; // [R12]
    end else begin : g_sel123
      assign local_sel = ports123_speed_select; // [R12]
    end

    assign period = bit_period(q.spd_sync); // [R10] [R11]
    assign rx_sum = q.rx_acc + CLK_STEP;
    assign tx_sum = q.tx_acc + CLK_STEP;
    assign half_sum = (period >> 1) + CLK_STEP;
    assign rx_tick = (rx_sum >= period);
    assign tx_tick = (tx_sum >= period);
    assign push = q.hold_valid && fifo_in_ready;
    assign accept = tx_valid[i] && !q.tx_held;

    assign tx_ready[i] = !q.tx_held;
    assign tx_done[i] = q.done;
    assign serial_tx_line[i] = q.line;

    byte_fifo #(
      .WIDTH(DATA_BITS),
      .DEPTH(FIFO_DEPTH)
    ) u_rx_fifo (
      .clock(clock),
      .rst(rst),
      .in_valid(q.hold_valid),
      .in_data(q.hold_data),
      .in_ready(fifo_in_ready),
      .out_valid(rx_valid[i]),
      .out_data(rx_data[i]),
      .out_ready(rx_ready[i])
    );

    always_comb begin
      s = q;
      s.ack_seen = 1'b0;
      s.done = 1'b0;

      // --------------------------------------------------------------
      // Input resynchronisation
      // --------------------------------------------------------------
      s.spd_meta = {global_speed_select, local_sel};
      s.spd_sync = q.spd_meta;
      s.rx_meta = serial_rx_line[i]; // [R13]
      s.rx_sync = q.rx_meta;
      s.rx_prev = q.rx_sync;

      // --------------------------------------------------------------
      // Receiver
      // --------------------------------------------------------------
      if (q.rx_state != RX_IDLE) begin
        s.rx_acc = rx_tick ? ACC_W'(rx_sum - period) : rx_sum;
      end
      case (q.rx_state)
        RX_IDLE: begin
          if (q.rx_sync && !q.rx_prev) begin
            // Half a bit plus the detect cycle, so ticks land mid-bit
            s.rx_state = RX_START; // [R14]
            s.rx_acc = (half_sum >= period) ? ACC_W'(half_sum - period) : half_sum;
          end
        end
        RX_START: begin
          if (rx_tick) begin
            s.rx_state = q.rx_sync ? RX_TYPE : RX_IDLE;
          end
        end
        RX_TYPE: begin
          if (rx_tick) begin
            if (q.rx_sync) begin
              s.rx_state = RX_DATA; // [R14]
              s.rx_cnt = '0;
            end else begin
              s.ack_seen = 1'b1; // [R6] [R14]
              s.rx_state = RX_IDLE;
            end
          end
        end
        RX_DATA: begin
          if (rx_tick) begin
            s.rx_shift = {q.rx_sync, q.rx_shift[DATA_BITS-1:1]}; // [R5]
            s.rx_cnt = q.rx_cnt + 1'b1;
            if (q.rx_cnt == LAST_DATA_IDX) begin
              s.rx_state = RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rx_tick) begin
            // Stop level not checked; a flow-controlled partner never overruns
            if (!q.hold_valid) begin
              s.hold_valid = 1'b1;
              s.hold_data = q.rx_shift;
            end
            s.rx_state = RX_IDLE;
          end
        end
        default: s.rx_state = RX_IDLE;
      endcase

      // Byte handed to the buffer; acknowledge owed
      if (push) begin
        s.hold_valid = 1'b0;
        s.ack_pending = 1'b1; // [R2]
      end

      // --------------------------------------------------------------
      // Transmitter
      // --------------------------------------------------------------
      if (accept) begin
        s.tx_held = 1'b1;
        s.tx_buf = tx_req[i];
      end
      if (q.ack_seen && q.await_ack) begin
        s.await_ack = 1'b0; // [R7]
        s.done = q.await_last; // [R9]
      end
      case (q.tx_state)
        TX_IDLE: begin
          s.tx_acc = '0;
          if (q.ack_pending && fifo_in_ready) begin
            // Acknowledges go first, between data packets
            s.tx_shift = ACK_PKT; // [R6] [R8] [R15]
            s.tx_cnt = ACK_PKT_BITS;
            // A byte landing in the same cycle keeps its acknowledge owed
            s.ack_pending = push; // [R2]
            s.tx_state = TX_SEND;
          end else if (q.tx_held && !q.await_ack) begin // [R7]
            s.tx_shift = {1'b0, q.tx_buf.data, 1'b1, 1'b1}; // [R4] [R5]
            s.tx_cnt = DATA_PKT_BITS;
            s.tx_held = 1'b0;
            s.await_ack = 1'b1;
            s.await_last = q.tx_buf.last;
            s.tx_state = TX_SEND;
          end
        end
        TX_SEND: begin
          s.tx_acc = tx_tick ? ACC_W'(tx_sum - period) : tx_sum;
          if (tx_tick) begin
            s.tx_shift = q.tx_shift >> 1;
            s.tx_cnt = q.tx_cnt - 1'b1;
            if (q.tx_cnt == 4'h1) begin
              s.tx_state = TX_IDLE;
            end
          end
        end
        default: s.tx_state = TX_IDLE;
      endcase
      s.line = (s.tx_state == TX_SEND) && s.tx_shift[0]; // [R3]
    end

    always_ff @(posedge clock) begin
      if (rst) begin
        q <= '0;
      end else begin
        q <= s;
      end
    end
  end

endmodule

// ==== link_sva.sv ====
// Purpose: Port checks on the link engine
// Assumes: Ports 0 and 1 carry traffic
// Notes: Bit lengths checked at known rates only
module link_sva
  import link_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic global_speed_select,
  input wire logic port0_speed_select,
  input wire logic ports123_speed_select,
  input wire logic [link_pkg::NPORTS-1:0] serial_tx_line,
  input wire logic [link_pkg::NPORTS-1:0] tx_valid,
  input wire logic [link_pkg::NPORTS-1:0] tx_ready,
  input wire logic [link_pkg::NPORTS-1:0] tx_done,
  input wire logic [link_pkg::NPORTS-1:0] rx_valid,
  input wire link_pkg::byte_t [link_pkg::NPORTS-1:0] rx_data,
  input wire logic [link_pkg::NPORTS-1:0] rx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic s10;
  logic s5;
  assign s10 = !global_speed_select && !port0_speed_select;
  assign s5 = !global_speed_select && ports123_speed_select;
  quiet_reset_a: assert property ($fell(rst) |-> !serial_tx_line && !tx_done
    && !rx_valid && tx_ready == 4'hF) else $error("outputs after reset");
  take_busy_a: assert property (tx_valid[0] && tx_ready[0] |=> !tx_ready[0])
    else $error("ready after take");
  done_pulse_a: assert property (tx_done[0] |=> !tx_done[0])
    else $error("done too long");
  rx_hold_a: assert property (rx_valid[0] && !rx_ready[0] |=> rx_valid[0] && $stable(rx_data[0]))
    else $error("rx byte lost");
  start_len_a: assert property ($rose(serial_tx_line[0]) && s10 |-> serial_tx_line[0] [*2])
    else $error("start bit short");
  low_len_a: assert property ($fell(serial_tx_line[0]) && s10 |-> !serial_tx_line[0] [*2])
    else $error("low bit short");
  slow_len_a: assert property ($rose(serial_tx_line[1]) && s5 |-> serial_tx_line[1] [*4])
    else $error("slow bit short");
  back_low_a: assert property ($rose(serial_tx_line[0]) |-> ##[1:60] !serial_tx_line[0])
    else $error("line stuck high");
  cover property (tx_done[0]);
  cover property (rx_valid[0] && rx_ready[0]);
  cover property ($rose(serial_tx_line[1]));
endmodule

bind serial_link_ports link_sva link_sva_i (.clock, .rst, .global_speed_select,
  .port0_speed_select, .ports123_speed_select, .serial_tx_line, .tx_valid,
  .tx_ready, .tx_done, .rx_valid, .rx_data, .rx_ready);

// ==== link_peer.sv ====
// Purpose: Far-end link port model
// Assumes: Same bit period as the engine
// Notes: Samples incoming bits mid-bit
module link_peer
  import link_pkg::*;
#(
  parameter int BIT_NS = 100
) (
  input wire logic from_dut,
  output logic to_dut
);
  timeunit 1ns;
  timeprecision 1ps;
  byte_t got[$];
  byte_t d;
  int acks = 0;
  bit auto_ack = 1;
  bit busy = 0;
  initial to_dut = 1'h0;
  // ------
  // Transmit
  // ------
  task automatic put(input logic [PKT_W-1:0] pkt, input int n);
    wait (!busy);
    busy = 1;
    for (int i = 0; i < n; i++) begin
      to_dut = pkt[i];
      #(BIT_NS);
    end
    to_dut = 1'h0;
    busy = 0;
  endtask
  task automatic send(input byte_t b);
    put({1'h0, b, 2'h3}, PKT_W);
  endtask
  // ------
  // Receive
  // ------
  always begin
    @(posedge from_dut);
    #(BIT_NS * 3 / 2);
    if (from_dut) begin
      for (int i = 0; i < DATA_BITS; i++) begin
        #(BIT_NS);
        d[i] = from_dut;
      end
      #(BIT_NS);
      got.push_back(d);
      if (auto_ack) fork put(ACK_PKT, 2); join_none
    end else begin
      acks++;
    end
  end
endmodule

// ==== tb_top.sv ====
// Purpose: Self-checking bench for the link engine
// Assumes: Peers on ports 0 and 1
// Notes: Ports 2 and 3 stay idle
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import link_pkg::*;
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic global_speed_select = 1'h0;
  logic port0_speed_select = 1'h0;
  logic ports123_speed_select = 1'h1;
  wire [NPORTS-1:0] serial_rx_line;
  logic [NPORTS-1:0] serial_tx_line, tx_ready, tx_done, rx_valid;
  logic [NPORTS-1:0] tx_valid = '0;
  logic [NPORTS-1:0] rx_ready = '0;
  tx_req_t [NPORTS-1:0] tx_req = '0;
  byte_t [NPORTS-1:0] rx_data;
  int error_cnt = 0;
  int comparisons = 0;
  int done0 = 0;
  always #20 clock = ~clock;
  always @(negedge clock) if (tx_done[0] === 1'h1) done0++;
  assign serial_rx_line[3:2] = 2'h0;
  serial_link_ports serial_link_ports_i (.clock, .rst, .global_speed_select,
    .port0_speed_select, .ports123_speed_select, .serial_rx_line, .serial_tx_line,
    .tx_valid, .tx_req, .tx_ready, .tx_done, .rx_valid, .rx_data, .rx_ready);
  link_peer p0 (.from_dut(serial_tx_line[0]), .to_dut(serial_rx_line[0]));
  link_peer #(.BIT_NS(200)) p1 (.from_dut(serial_tx_line[1]), .to_dut(serial_rx_line[1]));
  // ------
  // Helpers
  // ------
  task automatic step(input int n = 1);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic give_verdict;
    if (error_cnt == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic ck(input logic ok, input string m, input bit stop = 0);
    comparisons++;
    if (ok !== 1'h1) begin
      $display("MISMATCH %0t %s", $time, m);
      error_cnt++;
      if (stop) give_verdict();
    end
  endtask
  task automatic w0(input int n);
    for (int i = 0; i < 300 && p0.got.size() < n; i++) step();
    ck(p0.got.size() >= n, "no byte", 1);
  endtask
  task automatic wack(input int a, input logic exp);
    for (int i = 0; i < 99 && p0.acks == a; i++) step();
    ck((p0.acks > a) === exp, "ack");
  endtask
  task automatic offer(input int p, input byte_t b, input logic last);
    step();
    tx_valid[p] = 1'h1;
    tx_req[p] = '{b, last};
    for (int i = 0; i < 999 && !tx_ready[p]; i++) step();
    ck(tx_ready[p], "not taken", 1);
    step();
    tx_valid[p] = 1'h0;
  endtask
  // ------
  // Scenarios
  // ------
  task automatic s_reset;
    ck(serial_tx_line === 4'h0 && tx_ready === 4'hF && rx_valid === 4'h0, "reset");
  endtask
  task automatic s_msg;
    p0.auto_ack = 0;
    offer(0, 8'hA5, 1'h0);
    w0(1);
    offer(0, 8'h3C, 1'h1);
    step(99);
    ck(p0.got.size() == 1, "early send");
    p0.put(ACK_PKT, 2);
    w0(2);
    ck(p0.got[0] === 8'hA5 && p0.got[1] === 8'h3C && done0 == 0, "data");
    p0.put(ACK_PKT, 2);
    for (int i = 0; i < 30 && done0 == 0; i++) step();
    ck(done0 == 1, "done");
    p0.auto_ack = 1;
  endtask
  task automatic s_fill;
    int a;
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      a = p0.acks;
      p0.send(byte_t'(i + 8'h40));
      wack(a, i < FIFO_DEPTH - 1);
    end
    a = p0.acks;
    rx_ready[0] = 1'h1;
    step();
    rx_ready[0] = 1'h0;
    wack(a, 1'h1);
    rx_ready[0] = 1'h1;
    for (int i = 1; i < FIFO_DEPTH; i++) begin
      ck(rx_valid[0] === 1'h1 && rx_data[0] === byte_t'(i + 8'h40), "order");
      step();
    end
    rx_ready[0] = 1'h0;
    ck(rx_valid[0] === 1'h0, "not empty");
  endtask
  task automatic s_both;
    int a = p0.acks;
    fork
      p0.send(8'h96);
      offer(0, 8'h69, 1'h1);
    join
    step();
    wack(a, 1'h1);
    w0(3);
    ck(p0.got[2] === 8'h69 && rx_data[0] === 8'h96, "both ways");
    rx_ready[0] = 1'h1;
    step();
    rx_ready[0] = 1'h0;
  endtask
  task automatic s_speed;
    int a = p1.acks;
    int hi = 0;
    offer(1, 8'hC3, 1'h1);
    p1.send(8'h5A);
    for (int i = 0; i < 300 && (p1.acks == a || p1.got.size() == 0); i++) step();
    ck(p1.got[0] === 8'hC3 && rx_data[1] === 8'h5A, "port1 slow");
    global_speed_select = 1'h1;
    step(3);
    offer(0, 8'hE7, 1'h0);
    w0(4);
    ck(p0.got[3] === 8'hE7, "row 1,0");
    // Port 1 now at 20 Mbit/s: start and one bit span 100 ns
    offer(1, 8'h00, 1'h0);
    for (int i = 0; i < 40; i++) begin
      if (serial_tx_line[1] === 1'h1) hi++;
      step();
    end
    ck(hi >= 2 && hi <= 3, "row 1,1");
  endtask
  initial begin
    step(12);
    rst = 1'h0;
    step(3);
    s_reset();
    s_msg();
    s_fill();
    s_both();
    s_speed();
    give_verdict();
  end
endmodule
